/* usi_device.sv */
// Overview of operation
// - 4-bit counter readable, writable, raises overflow
// - shift register and counter share clock source
// - external clock counts both edges
// - clock from pin, timer match or software
// - two-wire start condition raises interrupt
// - two-wire holds clock low after start/overflow
// - spi modes 0 and 1, no select
// - eight clocks exchange bytes, flag marks done
// - master software toggles clock via strobe
// - one bit shifted per clock cycle
// - edge select clear: sample rise, shift fall
// - edge select set: sample fall, shift rise
// - data loaded half cycle before sampling
// - software clears counter before each byte
// - sixteen edges overflow the counter
// - overflow interrupt wakes idle processor
// - software handles byte before next transfer
module usi_device (
	input  wire logic        clk,
	input  wire logic        nrst,
	usi_link_if.device       link,
	input  wire logic        timer_match,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	output logic             irq
);
	typedef struct packed {
		logic       sck_s1;
		logic       sck_s2;
		logic       sck_prev;
		logic       di_s1;
		logic       di_s2;
		logic       di_prev;
		logic [7:0] shift_data;
		logic       do_bit;
		logic       sample;
		logic [3:0] cnt;
		logic       ovf;
		logic       strt;
		logic [1:0] src;
		logic       edge_sel;
		logic       sck_drive;
		logic       do_drive;
		logic       two_wire;
		logic       sck_level;
		logic [1:0] mask;
		logic       sck_o;
		logic       sck_oe;
		logic       irq;
		logic       waitreq;
		logic [7:0] rdata;
	} usi_dev_state_t;

	usi_dev_state_t st_reg;
	usi_dev_state_t st_next;

	logic       rise;
	logic       fall;
	logic       ev_sample;
	logic       ev_shift;
	logic       ev_int;
	logic       req;
	logic       wr_go;
	logic       strobe;
	logic [4:0] stepped;
	logic [7:0] ctrl_view;
	logic [7:0] stat_view;

	// edge finding on the synchronised pin, never on the first stage
	assign rise = st_reg.sck_s2 & ~st_reg.sck_prev;
	assign fall = ~st_reg.sck_s2 & st_reg.sck_prev;
	assign req = avs_read | avs_write;
	assign wr_go = avs_write & ~st_reg.waitreq & avs_byteenable[0];
	assign strobe = wr_go && avs_address == usi_pkg::OFS_CTRL
		&& avs_writedata[usi_pkg::CTRL_TOG_BIT];
	// internal sources move one whole bit per event
	assign ev_int = (st_reg.src == usi_pkg::USI_SRC_SW && strobe)
		|| (st_reg.src == usi_pkg::USI_SRC_TIMER && timer_match);
	// external source: one edge samples, the other shifts
	assign ev_sample = st_reg.src == usi_pkg::USI_SRC_EXT
		&& (st_reg.edge_sel ? fall : rise);
	assign ev_shift = st_reg.src == usi_pkg::USI_SRC_EXT
		&& (st_reg.edge_sel ? rise : fall);
	assign stepped = usi_pkg::cnt_step(st_reg.cnt);
	assign ctrl_view = {1'b0, 1'b0, st_reg.two_wire, st_reg.do_drive, st_reg.sck_drive,
		st_reg.edge_sel, st_reg.src};
	assign stat_view = {2'b00, st_reg.strt, st_reg.ovf, st_reg.cnt};

	// all next-state logic
	always_comb begin
		st_next = st_reg;
		st_next.sck_s1 = link.sck;
		st_next.sck_s2 = st_reg.sck_s1;
		st_next.sck_prev = st_reg.sck_s2;
		st_next.di_s1 = link.dev_di;
		st_next.di_s2 = st_reg.di_s1;
		st_next.di_prev = st_reg.di_s2;

		// shift path and counter run from the same event
		if (ev_int) begin
			st_next.shift_data = {st_reg.shift_data[6:0], st_reg.di_s2};
		end else if (ev_sample && st_reg.edge_sel) begin
			// mode 1 shifts on its sampling edge; its other edge only moves the pin
			st_next.shift_data = {st_reg.shift_data[6:0], st_reg.di_s2};
		end else if (ev_sample) begin
			st_next.sample = st_reg.di_s2;
		end else if (ev_shift && !st_reg.edge_sel) begin
			st_next.shift_data = {st_reg.shift_data[6:0], st_reg.sample};
		end
		// counter only moves on a selected source event
		if (ev_int || ev_sample || ev_shift) begin
			st_next.cnt = stepped[3:0];
		end

		// host write decode; accesses finish on the edge waitrequest is low
		if (wr_go) begin
			case (avs_address)
				usi_pkg::OFS_CTRL: begin
					st_next.src = avs_writedata[usi_pkg::CTRL_SRC_LSB +: 2];
					st_next.edge_sel = avs_writedata[usi_pkg::CTRL_EDGE_BIT];
					st_next.sck_drive = avs_writedata[usi_pkg::CTRL_SCKDR_BIT];
					st_next.do_drive = avs_writedata[usi_pkg::CTRL_DODR_BIT];
					st_next.two_wire = avs_writedata[usi_pkg::CTRL_TWOW_BIT];
					if (avs_writedata[usi_pkg::CTRL_TOG_BIT]) begin
						st_next.sck_level = ~st_reg.sck_level;
					end
				end
				usi_pkg::OFS_STATUS: begin
					// a direct count write beats a same-cycle clock event
					st_next.cnt = avs_writedata[usi_pkg::STAT_CNT_LSB +: 4];
					if (avs_writedata[usi_pkg::STAT_OVF_BIT]) begin
						st_next.ovf = 1'b0;
					end
					if (avs_writedata[usi_pkg::STAT_STRT_BIT]) begin
						st_next.strt = 1'b0;
					end
				end
				usi_pkg::OFS_MASK: begin
					st_next.mask = avs_writedata[usi_pkg::STAT_OVF_BIT +: 2];
				end
				usi_pkg::OFS_DATA: begin
					st_next.shift_data = avs_writedata[7:0];
				end
				default: begin
				end
			endcase
		end

		// mode 1 holds the pin until its change edge, so the first bit leads the sample
		if (!(st_reg.src == usi_pkg::USI_SRC_EXT && st_reg.edge_sel) || ev_shift) begin
			st_next.do_bit = st_next.shift_data[7];
		end

		// hardware sets win over a same-cycle software clear
		if ((ev_int || ev_sample || ev_shift) && stepped[4]) begin
			st_next.ovf = 1'b1;
		end
		// start: data falls while clock is high, two-wire only
		if (st_reg.two_wire && st_reg.sck_s2 && st_reg.sck_prev
			&& ~st_reg.di_s2 && st_reg.di_prev) begin
			st_next.strt = 1'b1;
		end

		// clock pin: stretched low in two-wire wait, else the software level
		if (st_next.two_wire && (st_next.strt || st_next.ovf)) begin
			st_next.sck_o = 1'b0;
			st_next.sck_oe = 1'b1;
		end else begin
			st_next.sck_o = st_next.sck_level;
			st_next.sck_oe = st_next.sck_drive;
		end

		// level interrupt keeps the core awake from idle
		st_next.irq = |({st_next.strt, st_next.ovf} & st_next.mask);

		// one wait cycle, then a single low cycle that completes the access
		st_next.waitreq = ~(req & st_reg.waitreq);
		if (req && st_reg.waitreq) begin
			case (avs_address)
				usi_pkg::OFS_CTRL:   st_next.rdata = ctrl_view;
				usi_pkg::OFS_STATUS: st_next.rdata = stat_view;
				usi_pkg::OFS_MASK:   st_next.rdata = {2'b00, st_reg.mask, 4'h0};
				usi_pkg::OFS_DATA:   st_next.rdata = st_reg.shift_data;
				default:             st_next.rdata = 8'h00;
			endcase
		end
	end

	// single state register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_reg <= '0;
			st_reg.sck_s1 <= 1'b1;
			st_reg.sck_s2 <= 1'b1;
			st_reg.sck_prev <= 1'b1;
			st_reg.di_s1 <= 1'b1;
			st_reg.di_s2 <= 1'b1;
			st_reg.di_prev <= 1'b1;
			st_reg.cnt <= usi_pkg::CNT_RST;
			st_reg.shift_data <= usi_pkg::DATA_RST;
			st_reg.mask <= usi_pkg::MASK_RST[usi_pkg::STAT_OVF_BIT +: 2];
			st_reg.waitreq <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	// no select input: the bus is always live in three-wire use
	assign link.dev_sck_o = st_reg.sck_o;
	assign link.dev_sck_oe = st_reg.sck_oe;
	assign link.dev_do = st_reg.do_bit;
	assign link.dev_do_oe = st_reg.do_drive;
	assign avs_readdata = {24'h000000, st_reg.rdata};
	assign avs_waitrequest = st_reg.waitreq;
	assign irq = st_reg.irq;
endmodule

/* usi_pkg.sv */
package usi_pkg;
	// avalon register byte offsets
	localparam logic [4:0] OFS_CTRL   = 5'h00;
	localparam logic [4:0] OFS_STATUS = 5'h04;
	localparam logic [4:0] OFS_MASK   = 5'h08;
	localparam logic [4:0] OFS_DATA   = 5'h0C;

	// control field positions
	localparam int CTRL_SRC_LSB   = 0;
	localparam int CTRL_EDGE_BIT  = 2;
	localparam int CTRL_SCKDR_BIT = 3;
	localparam int CTRL_DODR_BIT  = 4;
	localparam int CTRL_TWOW_BIT  = 5;
	localparam int CTRL_TOG_BIT   = 6;

	// status and mask field positions
	localparam int STAT_CNT_LSB  = 0;
	localparam int STAT_OVF_BIT  = 4;
	localparam int STAT_STRT_BIT = 5;

	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [3:0] CNT_RST  = 4'h0;

	// timing of a clock the partner makes as master; a half period must cover the
	// far end's three-clock edge delay plus our own two-flop input path
	localparam int CLK_PERIOD_NS   = 100;
	localparam int HALF_SCK_NS     = 800;
	localparam int HALF_SCK_CYC    = (HALF_SCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] HALF_SCK_LAST = 4'(HALF_SCK_CYC - 1);
	localparam logic [4:0] EDGES_PER_BYTE = 5'h10;

	// shift clock source selection
	typedef enum logic [1:0] {
		USI_SRC_NONE  = 2'b00,
		USI_SRC_SW    = 2'b01,
		USI_SRC_TIMER = 2'b10,
		USI_SRC_EXT   = 2'b11
	} usi_src_t;

	// 4-bit step with wrap flag in the top bit
	function automatic logic [4:0] cnt_step(input logic [3:0] c);
		cnt_step = {1'b0, c} + 5'h01;
	endfunction
endpackage

/* usi_link_if.sv */
interface usi_link_if;
	logic dev_sck_o;
	logic dev_sck_oe;
	logic dev_do;
	logic dev_do_oe;
	logic par_sck_o;
	logic par_sck_oe;
	logic par_do;
	logic par_do_oe;
	logic sck;
	logic dev_di;
	logic par_di;

	// wired clock line: any low driver wins, pulled high when undriven
	assign sck = ~((dev_sck_oe & ~dev_sck_o) | (par_sck_oe & ~par_sck_o));
	// data lines cross over, pulled high when undriven
	assign dev_di = par_do_oe ? par_do : 1'b1;
	assign par_di = dev_do_oe ? dev_do : 1'b1;

	modport device (
		output dev_sck_o,
		output dev_sck_oe,
		output dev_do,
		output dev_do_oe,
		input  sck,
		input  dev_di
	);
	modport partner (
		output par_sck_o,
		output par_sck_oe,
		output par_do,
		output par_do_oe,
		input  sck,
		input  par_di
	);
endinterface

/* usi_partner.sv */
module usi_partner (
	input  wire logic       clk,
	input  wire logic       nrst,
	usi_link_if.partner     link,
	input  wire logic       start,
	input  wire logic [7:0] tx_byte,
	input  wire logic       is_master,
	input  wire logic       edge_mode,
	output logic      [7:0] rx_byte,
	output logic            done,
	output logic            busy
);
	typedef enum logic [0:0] {
		PAR_IDLE = 1'b0,
		PAR_RUN  = 1'b1
	} usi_par_phase_t;

	typedef struct packed {
		usi_par_phase_t phase;
		logic           sck_s1;
		logic           sck_s2;
		logic           sck_prev;
		logic           di_s1;
		logic           di_s2;
		logic [3:0]     div;
		logic           sck;
		logic [4:0]     edges;
		logic [7:0]     shift_data;
		logic           do_bit;
		logic           sample;
		logic           master;
		logic           mode;
		logic           do_oe;
		logic [7:0]     rx;
		logic           done;
	} usi_par_state_t;

	usi_par_state_t st_reg;
	usi_par_state_t st_next;

	logic rise;
	logic fall;
	logic tick;

	// master makes its own edges by division; slave watches the synced pin
	assign tick = st_reg.master && st_reg.phase == PAR_RUN && st_reg.div == usi_pkg::HALF_SCK_LAST;
	assign rise = st_reg.master ? (tick && !st_reg.sck) : (st_reg.sck_s2 && !st_reg.sck_prev);
	assign fall = st_reg.master ? (tick && st_reg.sck) : (!st_reg.sck_s2 && st_reg.sck_prev);

	// all next-state logic
	always_comb begin
		st_next = st_reg;
		st_next.sck_s1 = link.sck;
		st_next.sck_s2 = st_reg.sck_s1;
		st_next.sck_prev = st_reg.sck_s2;
		st_next.di_s1 = link.par_di;
		st_next.di_s2 = st_reg.di_s1;
		st_next.done = 1'b0;
		case (st_reg.phase)
			PAR_IDLE: begin
				st_next.div = 4'h0;
				st_next.master = is_master;
				if (start) begin
					// data and driver are set up well ahead of the first edge
					st_next.shift_data = tx_byte;
					st_next.mode = edge_mode;
					st_next.do_oe = 1'b1;
					st_next.edges = 5'h00;
					st_next.phase = PAR_RUN;
				end
			end
			PAR_RUN: begin
				st_next.div = tick ? 4'h0 : st_reg.div + 4'h1;
				if (tick) begin
					st_next.sck = ~st_reg.sck;
				end
				if (rise || fall) begin
					st_next.edges = st_reg.edges + 5'h01;
					if ((st_reg.mode ? fall : rise)) begin
						if (st_reg.mode) begin
							st_next.shift_data = {st_reg.shift_data[6:0], st_reg.di_s2};
						end else begin
							st_next.sample = st_reg.di_s2;
						end
					end else if (!st_reg.mode) begin
						st_next.shift_data = {st_reg.shift_data[6:0], st_reg.sample};
					end
				end
				// byte swapped after sixteen edges
				if (st_next.edges == usi_pkg::EDGES_PER_BYTE) begin
					st_next.rx = st_next.shift_data;
					st_next.done = 1'b1;
					st_next.do_oe = st_reg.master;
					st_next.phase = PAR_IDLE;
				end
			end
			default: begin
				st_next.phase = PAR_IDLE;
			end
		endcase
		// mode 1 moves the pin only on its leading edge
		if (!st_next.mode || rise) begin
			st_next.do_bit = st_next.shift_data[7];
		end
	end

	// single state register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_reg <= '0;
			st_reg.phase <= PAR_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	assign link.par_sck_o = st_reg.sck;
	assign link.par_sck_oe = st_reg.master;
	assign link.par_do = st_reg.do_bit;
	assign link.par_do_oe = st_reg.do_oe;
	assign rx_byte = st_reg.rx;
	assign done = st_reg.done;
	assign busy = st_reg.phase == PAR_RUN;
endmodule

/* usi_link_sva.sv */
module usi_link_sva (
	input logic clk,
	input logic nrst,
	input logic dev_sck_o,
	input logic dev_sck_oe,
	input logic dev_do_oe,
	input logic par_sck_o,
	input logic par_sck_oe,
	input logic par_do_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	logic       sck_q;
	logic [3:0] quiet;
	logic [4:0] edges;
	// frame tracker: twelve still cycles end a frame, well above the eight-cycle half period
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sck_q <= 1'b0;
			quiet <= 4'hF;
			edges <= 5'h00;
		end else begin
			sck_q <= par_sck_o;
			if (par_sck_o != sck_q) begin
				quiet <= 4'h0;
				edges <= (quiet >= 4'hC) ? 5'h01 : edges + 5'h01;
			end else if (quiet != 4'hF) begin
				quiet <= quiet + 4'h1;
			end
		end
	end
	// one half period of the partner clock, eight system clocks
	sequence half_hold;
		$stable(par_sck_o)[*7];
	endsequence
	reset_idle_a: assert property ($rose(nrst) |-> !dev_sck_oe && !dev_do_oe && !par_sck_oe && !par_do_oe)
		else $error("drivers enabled right after reset");
	sck_half_a: assert property ($changed(par_sck_o) |=> half_hold)
		else $error("link clock half period too short");
	sck_driven_a: assert property ($changed(par_sck_o) |-> par_sck_oe)
		else $error("link clock toggled while not driven");
	edge_limit_a: assert property (edges <= 5'h10)
		else $error("more than sixteen edges in one frame");
	frame_end_a: assert property (quiet == 4'hC |-> edges == 5'h10 && !par_sck_o)
		else $error("frame ended without sixteen edges or clock not idle low");
	strobe_gap_a: assert property ($changed(dev_sck_o) |=> $stable(dev_sck_o)[*2])
		else $error("device clock toggled twice for one strobe");
	data_driven_a: assert property ($changed(par_sck_o) |-> $past(par_do_oe))
		else $error("partner data not driven during clocking");
	one_master_a: assert property ($changed(par_sck_o) |-> !dev_sck_oe)
		else $error("both ends drive the link clock");
endmodule

/* universal_serial_three_wire_bench.sv */
module universal_serial_three_wire_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [4:0] RC = usi_pkg::OFS_CTRL;
	localparam logic [4:0] RS = usi_pkg::OFS_STATUS;
	localparam logic [4:0] RM = usi_pkg::OFS_MASK;
	localparam logic [4:0] RD = usi_pkg::OFS_DATA;
	logic        clk, nrst, timer_match, avs_read, avs_write, avs_waitrequest, irq;
	logic        start, is_master, edge_mode, done, busy;
	logic [4:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0]  avs_byteenable;
	logic [7:0]  tx_byte, rx_byte, rd;
	int          num_errors, n_tests;
	usi_link_if usi_link_if_inst ();
	usi_device usi_device_inst (.clk(clk), .nrst(nrst), .link(usi_link_if_inst.device),
		.timer_match(timer_match), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));
	usi_partner usi_partner_inst (.clk(clk), .nrst(nrst), .link(usi_link_if_inst.partner),
		.start(start), .tx_byte(tx_byte), .is_master(is_master), .edge_mode(edge_mode),
		.rx_byte(rx_byte), .done(done), .busy(busy));
	usi_link_sva usi_link_sva_inst (.clk(clk), .nrst(nrst),
		.dev_sck_o(usi_link_if_inst.dev_sck_o), .dev_sck_oe(usi_link_if_inst.dev_sck_oe),
		.dev_do_oe(usi_link_if_inst.dev_do_oe), .par_sck_o(usi_link_if_inst.par_sck_o),
		.par_sck_oe(usi_link_if_inst.par_sck_oe), .par_do_oe(usi_link_if_inst.par_do_oe));
	// 10 MHz system clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_val({7'h00, got}, {7'h00, exp});
	endtask
	// one avalon cycle: request held until waitrequest is seen low
	task automatic av(input logic [4:0] a, input logic w, input logic [7:0] d, input logic [3:0] be);
		int n;
		n = 0;
		@(posedge clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= ~w;
		avs_writedata <= {24'h000000, d};
		avs_byteenable <= be;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		rd = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (avs_waitrequest !== 1'b0) num_errors++;
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		av(a, 1'b1, d, 4'hF);
	endtask
	task automatic rdchk(input logic [4:0] a, input logic [7:0] e);
		av(a, 1'b0, 8'h00, 4'hF);
		chk_val(rd, e);
	endtask
	// reset values, a write with lane 0 off and an unmapped place
	task automatic test_reset_regs;
		rdchk(RC, usi_pkg::CTRL_RST);
		rdchk(RS, {4'h0, usi_pkg::CNT_RST});
		rdchk(RM, usi_pkg::MASK_RST);
		av(RD, 1'b1, 8'h5A, 4'h0);
		rdchk(RD, usi_pkg::DATA_RST);
		wr(5'h10, 8'hFF);
		rdchk(5'h10, 8'h00);
		chk_bit(irq, 1'b0);
	endtask
	// partner-clocked byte exchange; the flag must mark completion
	task automatic frame(input logic m, input logic [7:0] dv, input logic [7:0] pv);
		int n;
		wr(RC, {3'b000, 1'b1, 1'b0, m, 2'b11}); // external pin source, data driven
		wr(RD, dv);
		wr(RS, 8'h10);
		@(posedge clk);
		start <= 1'b1;
		tx_byte <= pv;
		edge_mode <= m;
		@(posedge clk);
		start <= 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		chk_bit(done, 1'b1);
		chk_val(rx_byte, dv);
		repeat (4) @(posedge clk); // pin edges reach the device about three clocks late
		rdchk(RD, pv);
		rdchk(RS, 8'h10);
	endtask
	task automatic test_exchange;
		frame(1'b0, 8'hC1, 8'h38);
		frame(1'b1, 8'h4E, 8'hB2);
	endtask
	// overflow interrupt: masked, unmasked, cleared by writing one
	task automatic test_irq;
		chk_bit(irq, 1'b0);
		wr(RM, 8'h10);
		rdchk(RM, 8'h10);
		chk_bit(irq, 1'b1);
		wr(RS, 8'h10);
		rdchk(RS, 8'h00);
		chk_bit(irq, 1'b0);
		wr(RM, 8'h00);
	endtask
	// software strobe counts once per write, wrapping 15 to 0 sets the flag
	task automatic test_count_wrap;
		wr(RC, 8'h01);
		wr(RS, 8'h1E);
		wr(RC, 8'h41);
		rdchk(RS, 8'h0F);
		wr(RC, 8'h41);
		rdchk(RS, 8'h10);
		rdchk(RC, 8'h01);
		// two-wire wait: overflow still set, so the device must hold the clock low
		wr(RC, 8'h20);
		rdchk(RC, 8'h20);
		chk_bit(usi_link_if_inst.dev_sck_oe, 1'b1);
		chk_bit(usi_link_if_inst.dev_sck_o, 1'b0);
		wr(RS, 8'h10);
		rdchk(RS, 8'h00);
		chk_bit(usi_link_if_inst.dev_sck_oe, 1'b0);
	endtask
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge clk);
			timer_match <= 1'b1;
			@(posedge clk);
			timer_match <= 1'b0;
		end
	endtask
	// timer source counts, no source holds the count
	task automatic test_timer_src;
		wr(RS, 8'h10);
		wr(RC, 8'h02);
		pulse(3);
		rdchk(RS, 8'h03);
		wr(RC, 8'h00);
		pulse(2);
		rdchk(RS, 8'h03);
	endtask
	task automatic finish_test;
		if (num_errors == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// watchdog far beyond the few hundred cycles the run needs
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		finish_test;
	end
	initial begin
		nrst = 1'b0;
		timer_match = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 5'h00;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'h0;
		start = 1'b0;
		tx_byte = 8'h00;
		is_master = 1'b1; // partner clocks every frame, set while idle
		edge_mode = 1'b0;
		num_errors = 0;
		n_tests = 0;
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		test_reset_regs;
		test_exchange;
		test_irq;
		test_count_wrap;
		test_timer_src;
		finish_test;
	end
endmodule
